/* src/pdw_decode.sv */
/*
 * Planar write instruction decoder and sequencer of the video DMA engine.
 * Assumes instruction words arrive in program order from the bus initiator's
 * fetch path, and that a transfer engine moves or discards the bytes of each
 * issued plane command from the luma_fifo, blue_chroma_fifo or red_chroma_fifo.
 */
//
// Behaviour
// - Opcode 1001 is five-word three-plane write
// - Word0 holds count, enables, status, irq, line flags
// - Word1 low twelve bits: blue chroma count
// - Word1 bits 27:16: red chroma count
// - Word2 is luma target address
// - Word3 is blue chroma target address
// - Word4 is red chroma target address
// - Opcode 1011: three words, luma write, chroma discarded
// - Skip variant word0 laid out as three-plane
// - Skip variant word1 low: blue discard count
// - Skip variant word1 27:16: red discard count
// - Planar handling only while planar status active
// - Audio instance refuses planar instructions
`timescale 1ns/100ps
`include "pdw_defines.svh"

module pdw_decode (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_planar_mode,
   input wire logic i_audio_instance,
   input wire logic i_instr_valid,
   input wire logic [31:0] i_instr_data,
   output logic o_instr_ready,
   output logic o_foreign_instr,
   output logic o_xfer_valid,
   input wire logic i_xfer_ready,
   output logic [1:0] o_xfer_plane,
   output logic [31:0] o_xfer_addr,
   output logic [11:0] o_xfer_count,
   output logic o_xfer_discard,
   output logic o_done,
   output logic [3:0] o_byte_en,
   output logic [7:0] o_program_status_flags,
   output logic o_irq_req,
   output logic o_line_end_flag,
   output logic o_line_begin_flag,
   output logic o_busy
);

   function automatic logic [11:0] pdw_cnt_a(input logic [31:0] w);
      pdw_cnt_a = w[`PDW_CNT_A_HI:`PDW_CNT_A_LO];
   endfunction

   function automatic logic [11:0] pdw_cnt_b(input logic [31:0] w);
      pdw_cnt_b = w[`PDW_CNT_B_HI:`PDW_CNT_B_LO];
   endfunction

   pdw_pkg::pdw_state_t state_q, state_d;
   logic [2:0] word_idx_q, word_idx_d;
   logic [2:0] words_q, words_d;
   logic skip_chroma_q, skip_chroma_d;
   logic [31:0] word0_q, word0_d;
   logic [11:0] cnt_luma_q, cnt_luma_d;
   logic [11:0] cnt_blue_q, cnt_blue_d;
   logic [11:0] cnt_red_q, cnt_red_d;
   logic [31:0] addr_luma_q, addr_luma_d;
   logic [31:0] addr_blue_q, addr_blue_d;
   logic [31:0] addr_red_q, addr_red_d;
   logic [1:0] plane_q, plane_d;
   logic [31:0] xaddr_q, xaddr_d;
   logic [11:0] xcnt_q, xcnt_d;
   logic xdisc_q, xdisc_d;
   logic done_q, done_d;
   logic [3:0] opcode;
   logic is_three, is_skip, ours, take;

   assign opcode = i_instr_data[`PDW_OP_HI:`PDW_OP_LO];
   assign is_three = (opcode == `PDW_OP_THREE_PLANE);
   assign is_skip = (opcode == `PDW_OP_LUMA_SKIP);
   assign ours = (is_three || is_skip) && i_planar_mode && !i_audio_instance;

   always_comb begin
      o_instr_ready = 1'b0;
      o_foreign_instr = 1'b0;
      if (state_q == pdw_pkg::PDW_S_IDLE) begin
         o_instr_ready = i_instr_valid && ours;
         o_foreign_instr = i_instr_valid && !ours;
      end else if (state_q == pdw_pkg::PDW_S_FETCH) begin
         o_instr_ready = i_instr_valid;
      end
   end

   assign take = i_instr_valid && o_instr_ready;

   always_comb begin
      state_d = state_q;
      word_idx_d = word_idx_q;
      words_d = words_q;
      skip_chroma_d = skip_chroma_q;
      word0_d = word0_q;
      cnt_luma_d = cnt_luma_q;
      cnt_blue_d = cnt_blue_q;
      cnt_red_d = cnt_red_q;
      addr_luma_d = addr_luma_q;
      addr_blue_d = addr_blue_q;
      addr_red_d = addr_red_q;
      plane_d = plane_q;
      xaddr_d = xaddr_q;
      xcnt_d = xcnt_q;
      xdisc_d = xdisc_q;
      done_d = 1'b0;
      case (state_q)
         pdw_pkg::PDW_S_IDLE: begin
            if (take) begin
               word0_d = i_instr_data;
               cnt_luma_d = pdw_cnt_a(i_instr_data);
               skip_chroma_d = is_skip;
               words_d = is_skip ? `PDW_WORDS_LUMA_SKIP : `PDW_WORDS_THREE_PLANE;
               addr_blue_d = 32'h0000_0000;
               addr_red_d = 32'h0000_0000;
               word_idx_d = 3'h1;
               state_d = pdw_pkg::PDW_S_FETCH;
            end
         end
         pdw_pkg::PDW_S_FETCH: begin
            if (take) begin
               case (word_idx_q)
                  3'h1: begin
                     // Bits outside both counts are not looked at
                     cnt_blue_d = pdw_cnt_a(i_instr_data);
                     cnt_red_d = pdw_cnt_b(i_instr_data);
                  end
                  3'h2: addr_luma_d = i_instr_data;
                  3'h3: addr_blue_d = i_instr_data;
                  default: addr_red_d = i_instr_data;
               endcase
               word_idx_d = word_idx_q + 3'h1;
               if (word_idx_q + 3'h1 == words_q) begin
                  state_d = pdw_pkg::PDW_S_ISSUE;
                  plane_d = pdw_pkg::PDW_PLANE_LUMA;
                  xaddr_d = (word_idx_q == 3'h2) ? i_instr_data : addr_luma_q;
                  xcnt_d = cnt_luma_q;
                  xdisc_d = 1'b0;
               end
            end
         end
         pdw_pkg::PDW_S_ISSUE: begin
            if (i_xfer_ready) begin
               if (plane_q == pdw_pkg::PDW_PLANE_LUMA) begin
                  plane_d = pdw_pkg::PDW_PLANE_BLUE;
                  xaddr_d = addr_blue_q;
                  xcnt_d = cnt_blue_q;
                  xdisc_d = skip_chroma_q;
               end else if (plane_q == pdw_pkg::PDW_PLANE_BLUE) begin
                  plane_d = pdw_pkg::PDW_PLANE_RED;
                  xaddr_d = addr_red_q;
                  xcnt_d = cnt_red_q;
                  xdisc_d = skip_chroma_q;
               end else begin
                  state_d = pdw_pkg::PDW_S_DONE;
               end
            end
         end
         pdw_pkg::PDW_S_DONE: begin
            done_d = 1'b1;
            state_d = pdw_pkg::PDW_S_IDLE;
         end
         default: state_d = pdw_pkg::PDW_S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= pdw_pkg::PDW_S_IDLE;
         word_idx_q <= 3'h0;
         words_q <= 3'h0;
         skip_chroma_q <= 1'b0;
         word0_q <= 32'h0000_0000;
         cnt_luma_q <= 12'h000;
         cnt_blue_q <= 12'h000;
         cnt_red_q <= 12'h000;
         addr_luma_q <= 32'h0000_0000;
         addr_blue_q <= 32'h0000_0000;
         addr_red_q <= 32'h0000_0000;
         plane_q <= 2'h0;
         xaddr_q <= 32'h0000_0000;
         xcnt_q <= 12'h000;
         xdisc_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         word_idx_q <= word_idx_d;
         words_q <= words_d;
         skip_chroma_q <= skip_chroma_d;
         word0_q <= word0_d;
         cnt_luma_q <= cnt_luma_d;
         cnt_blue_q <= cnt_blue_d;
         cnt_red_q <= cnt_red_d;
         addr_luma_q <= addr_luma_d;
         addr_blue_q <= addr_blue_d;
         addr_red_q <= addr_red_d;
         plane_q <= plane_d;
         xaddr_q <= xaddr_d;
         xcnt_q <= xcnt_d;
         xdisc_q <= xdisc_d;
         done_q <= done_d;
      end
   end

   assign o_xfer_valid = (state_q == pdw_pkg::PDW_S_ISSUE);
   assign o_xfer_plane = plane_q;
   assign o_xfer_addr = xaddr_q;
   assign o_xfer_count = xcnt_q;
   assign o_xfer_discard = xdisc_q;
   assign o_busy = (state_q != pdw_pkg::PDW_S_IDLE);
   assign o_done = done_q;
   // Reserved bit 25 of word0 is never used
   assign o_byte_en = word0_q[`PDW_BE_HI:`PDW_BE_LO];
   assign o_program_status_flags = word0_q[`PDW_STAT_HI:`PDW_STAT_LO];
   assign o_irq_req = word0_q[`PDW_IRQ_BIT];
   assign o_line_end_flag = word0_q[`PDW_LINE_END_BIT];
   assign o_line_begin_flag = word0_q[`PDW_LINE_BEGIN_BIT];

endmodule

/* src/pdw_defines.svh */
/*
 * Field positions, opcodes and word counts of the planar write instructions.
 * Assumes nothing; definitions only.
 */
`ifndef PDW_DEFINES_SVH
`define PDW_DEFINES_SVH

`define PDW_OP_HI 31
`define PDW_OP_LO 28
`define PDW_OP_THREE_PLANE 4'h9
`define PDW_OP_LUMA_SKIP 4'hB
`define PDW_WORDS_THREE_PLANE 3'h5
`define PDW_WORDS_LUMA_SKIP 3'h3
`define PDW_CNT_A_HI 11
`define PDW_CNT_A_LO 0
`define PDW_CNT_B_HI 27
`define PDW_CNT_B_LO 16
`define PDW_BE_HI 15
`define PDW_BE_LO 12
`define PDW_STAT_HI 23
`define PDW_STAT_LO 16
`define PDW_IRQ_BIT 24
`define PDW_LINE_END_BIT 26
`define PDW_LINE_BEGIN_BIT 27

`endif

/* src/pdw_pkg.sv */
/*
 * Types for the planar write instruction decoder.
 * Assumes the defines header is compiled alongside.
 */
package pdw_pkg;

   typedef enum logic [3:0] {
      PDW_S_IDLE  = 4'h1,
      PDW_S_FETCH = 4'h2,
      PDW_S_ISSUE = 4'h4,
      PDW_S_DONE  = 4'h8
   } pdw_state_t;

   typedef enum logic [1:0] {
      PDW_PLANE_LUMA = 2'h0,
      PDW_PLANE_BLUE = 2'h1,
      PDW_PLANE_RED  = 2'h2
   } pdw_plane_t;

endpackage

/* tb/pdw_chk.sv */
/* Port assertions for the planar write decoder.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/100ps
module pdw_chk (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_planar_mode,
   input wire logic i_audio_instance,
   input wire logic i_instr_valid,
   input wire logic o_instr_ready,
   input wire logic o_foreign_instr,
   input wire logic o_xfer_valid,
   input wire logic i_xfer_ready,
   input wire logic [1:0] o_xfer_plane,
   input wire logic [31:0] o_xfer_addr,
   input wire logic [11:0] o_xfer_count,
   input wire logic o_xfer_discard,
   input wire logic o_done,
   input wire logic o_busy
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_red_taken;
      o_xfer_valid && i_xfer_ready && o_xfer_plane == 2'h2;
   endsequence
   sequence s_finish;
      !o_xfer_valid && o_busy ##1 o_done && !o_busy;
   endsequence
   AST_AUDIO: assert property (i_audio_instance && i_instr_valid && !o_busy |-> o_foreign_instr && !o_instr_ready)
      else $error("audio word accepted");
   AST_PACKED: assert property (!i_planar_mode && i_instr_valid && !o_busy |-> !o_instr_ready)
      else $error("packed mode word accepted");
   AST_LUMA_FIRST: assert property (o_xfer_valid && i_xfer_ready && o_xfer_plane == 2'h0 |=> o_xfer_valid && o_xfer_plane == 2'h1)
      else $error("blue plane does not follow luma");
   AST_RED_LAST: assert property (s_red_taken |=> s_finish)
      else $error("done not two cycles after red plane");
   AST_DONE_PULSE: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   AST_HOLD: assert property (o_xfer_valid && !i_xfer_ready |=> o_xfer_valid && $stable(o_xfer_plane) && $stable(o_xfer_addr) && $stable(o_xfer_count) && $stable(o_xfer_discard))
      else $error("command dropped before taken");
   AST_LUMA_WRITTEN: assert property (o_xfer_valid && o_xfer_plane == 2'h0 |-> !o_xfer_discard)
      else $error("luma plane discarded");
   AST_ISSUE_BUSY: assert property (o_xfer_valid |-> o_busy && !o_instr_ready)
      else $error("word taken while issuing");
endmodule
bind pdw_decode pdw_chk pdw_chk_inst (
   .i_clk(i_clk),
   .i_sys_rst(i_sys_rst),
   .i_planar_mode(i_planar_mode),
   .i_audio_instance(i_audio_instance),
   .i_instr_valid(i_instr_valid),
   .o_instr_ready(o_instr_ready),
   .o_foreign_instr(o_foreign_instr),
   .o_xfer_valid(o_xfer_valid),
   .i_xfer_ready(i_xfer_ready),
   .o_xfer_plane(o_xfer_plane),
   .o_xfer_addr(o_xfer_addr),
   .o_xfer_count(o_xfer_count),
   .o_xfer_discard(o_xfer_discard),
   .o_done(o_done),
   .o_busy(o_busy)
);

/* tb/pdw_engine.sv */
/* Transfer engine model: takes plane commands, promptly or every other cycle.
   Assumes the decoder's clock and reset. */
`timescale 1ns/100ps
module pdw_engine (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_slow,
   output logic o_xfer_ready
);
   logic ready_q;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_slow) ready_q <= !i_sys_rst;
      else ready_q <= !ready_q;
   end
   assign o_xfer_ready = ready_q;
endmodule

/* tb/tb.sv */
/* Self-checking bench for the planar write decoder.
   Assumes the engine model answers the transfer port. */
`timescale 1ns/100ps
module tb;
   logic clk, rst, pm, au, iv, slow, rdy, frn, xv, xr, disc, done, irq, lend, lbeg, busy;
   logic [31:0] d, adr;
   logic [1:0] pl;
   logic [11:0] cnt;
   logic [3:0] be;
   logic [7:0] st;
   int n_errors = 0, num_checks = 0, cyc = 0;
   pdw_decode pdw_decode_inst (.i_clk(clk), .i_sys_rst(rst), .i_planar_mode(pm), .i_audio_instance(au),
      .i_instr_valid(iv), .i_instr_data(d), .o_instr_ready(rdy), .o_foreign_instr(frn), .o_xfer_valid(xv),
      .i_xfer_ready(xr), .o_xfer_plane(pl), .o_xfer_addr(adr), .o_xfer_count(cnt), .o_xfer_discard(disc),
      .o_done(done), .o_byte_en(be), .o_program_status_flags(st), .o_irq_req(irq),
      .o_line_end_flag(lend), .o_line_begin_flag(lbeg), .o_busy(busy));
   pdw_engine pdw_engine_inst (.i_clk(clk), .i_sys_rst(rst), .i_slow(slow), .o_xfer_ready(xr));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task put(logic [31:0] w);
      @(negedge clk);
      iv = 1;
      d = w;
      #1 chk("instr_ready", 1, rdy);
      chk("foreign", 0, frn);
      @(posedge clk);
   endtask
   task xp(logic [1:0] p, logic [31:0] a, logic [11:0] c, logic ds);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         iv = 0;
         k++;
      end while (!(xv === 1 && xr === 1) && k < 20);
      chk("xfer_valid", 1, xv);
      chk("busy", 1, busy);
      chk("plane", p, pl);
      chk("addr", a, adr);
      chk("count", c, cnt);
      chk("discard", ds, disc);
   endtask
   task fin(logic [3:0] b, logic [7:0] s, logic [2:0] f);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (done !== 1 && k < 5);
      chk("done", 1, done);
      chk("byte_en", b, be);
      chk("status", s, st);
      chk("irq_line_flags", f, {irq, lend, lbeg});
   endtask
   task t_three;
      put(32'h9FA5C123);
      put(32'hF456F789);
      put(32'h10000000);
      put(32'h20000004);
      put(32'h30000008);
      xp(2'h0, 32'h10000000, 12'h123, 0);
      xp(2'h1, 32'h20000004, 12'h789, 0);
      xp(2'h2, 32'h30000008, 12'h456, 0);
      fin(4'hC, 8'hA5, 3'h7);
      $display("test three_plane done");
   endtask
   task t_skip;
      slow = 1;
      put(32'hB4000FFF);
      put(32'h0ABC0DEF);
      put(32'h89ABCDEF);
      xp(2'h0, 32'h89ABCDEF, 12'hFFF, 0);
      xp(2'h1, 32'h0, 12'hDEF, 1);
      xp(2'h2, 32'h0, 12'hABC, 1);
      fin(4'h0, 8'h00, 3'h2);
      slow = 0;
      $display("test luma_skip done");
   endtask
   task refuse(logic [31:0] w, logic p, logic a);
      @(negedge clk);
      pm = p;
      au = a;
      iv = 1;
      d = w;
      #1 chk("instr_ready", 0, rdy);
      chk("foreign", 1, frn);
      @(negedge clk);
      chk("busy", 0, busy);
      iv = 0;
      pm = 1;
      au = 0;
      $display("test refusal done");
   endtask
   task t_reset;
      put(32'h9FA5C123);
      put(32'hF456F789);
      @(negedge clk);
      iv = 0;
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      chk("busy", 0, busy);
      chk("xfer_valid", 0, xv);
      chk("done", 0, done);
      chk("instr_ready", 0, rdy);
      chk("byte_en", 0, be);
      chk("status", 0, st);
      chk("irq_line_flags", 0, {irq, lend, lbeg});
      $display("test reset done");
   endtask
   task end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_sim;
      end
   end
   initial begin
      rst = 1;
      pm = 1;
      au = 0;
      iv = 0;
      slow = 0;
      d = 0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst = 0;
      t_three;
      t_skip;
      refuse(32'h9FA5C123, 0, 0);
      refuse(32'hB4000FFF, 1, 1);
      refuse(32'h10000010, 1, 0);
      t_reset;
      t_skip;
      end_sim;
   end
endmodule
